// File: lds_cfg.svh
// Constants for the load diagnostic and supply-loss logic
`ifndef LDS_CFG_SVH
`define LDS_CFG_SVH

`define LDS_NUM_CH 4
`define LDS_CLK_PERIOD_NS 10
`define LDS_LED_OPENLOAD_SELECT_PERIOD_NS 1000
`define LDS_LED_OPENLOAD_SELECT_CYCLES ((`LDS_LED_OPENLOAD_SELECT_PERIOD_NS + `LDS_CLK_PERIOD_NS - 1) / `LDS_CLK_PERIOD_NS)
`define LDS_DUTY_W 7
`define LDS_DUTY_FULL 7'h7F
`define LDS_ALL_ON 4'hF
`define LDS_ALL_OFF 4'h0

`endif

// File: lds_host_model.sv
// Host-side model: sixteen-bit frames ending in a write strobe or a read report
`timescale 1ns/1ps
module lds_host_model (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Requests from the bench: 0 write, 1 diagnostic read, 2 status read
    input wire logic i_start,
    input wire logic [1:0] i_kind,
    // Frame strobes towards the block
    output logic o_busy,
    output logic o_cfg_wr,
    output logic o_frame_done,
    output logic o_read_diag,
    output logic o_read_status
);
    logic [4:0] bits_q;
    logic [1:0] kind_q;
    logic toggle_q;
    logic last_bit;

    assign last_bit = bits_q == 5'h01;
    // Qualifiers mean something only with the done strobe, so elsewhere they churn
    assign o_read_diag = o_frame_done ? kind_q == 2'h1 : toggle_q;
    assign o_read_status = o_frame_done ? kind_q == 2'h2 : ~toggle_q;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            bits_q <= 5'h00;
            kind_q <= 2'h0;
            toggle_q <= 1'h0;
            o_busy <= 1'h0;
            o_cfg_wr <= 1'h0;
            o_frame_done <= 1'h0;
        end else begin
            toggle_q <= ~toggle_q;
            o_cfg_wr <= last_bit && kind_q == 2'h0;
            o_frame_done <= last_bit;
            if (i_start && !o_busy) begin
                bits_q <= 5'h10;
                kind_q <= i_kind;
                o_busy <= 1'h1;
            end else if (bits_q != 5'h00) begin
                bits_q <= bits_q - 5'h01;
                o_busy <= !last_bit;
            end
        end
    end
endmodule : lds_host_model

// File: lds_load_diag.sv
// Load diagnostics, sense routing and supply-loss handling of a four-output switch
//
// Function
// [R1] Below on-state threshold sets lit open-load flag; output stays on, fault pin untouched.
// [R2] Per-output select bit picks bulb or LED on-state open-load threshold.
// [R3] LED open-load checked once per period, only while fully on.
// [R4] Open-load flag clears only once condition gone and a read happened; the code also clears it on any configuration reset.
// [R5] Per-output disable bit suppresses on-state open-load detection.
// [R6] Sense pin reports selected output current or flag temperature per configuration.
// [R7] Current copy driven only while selected output is on.
// [R8] Current copy disabled in fail-safe mode.
// [R9] Normal mode latches overheat warning; a read clears it.
// [R10] Supply clamp cancels turn-off and switches all four outputs on.
// [R11] Ground loss turns all outputs off.
// [R12] Logic supply loss or enabled fail level resets configuration registers.
// [R13] Without logic supply, direct inputs drive outputs while battery is in range.
// [R14] Protections stay active during logic loss with all-zero defaults.
// [R15] Battery power-on reset turns outputs off, restarts later, clears retry counter.
// [R16] Host commands outputs off below 5.0 V battery.
// [R17] Battery loss with logic supply and reset high keeps configuration.
// [R18] Battery loss reported as undervoltage flag.
// [R19] Both supplies at power-on reset clear all registers and latched faults.
// [R20] Host transfers are sixteen-bit words, most significant bit first.
// [R21] Read-to-clear flags clear after the reporting frame, reset if still present.
`timescale 1ns/1ps
`include "lds_cfg.svh"

module lds_load_diag
    import lds_pkg::*;
#(
    parameter int NCH = `LDS_NUM_CH,
    parameter int LED_OPENLOAD_SELECT_CYC = `LDS_LED_OPENLOAD_SELECT_CYCLES
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Configuration write from the serial port
    input wire logic i_cfg_wr,
    input wire logic [NCH-1:0] i_led_openload_select,
    input wire logic [NCH-1:0] i_lit_openload_disable,
    input wire logic [NCH-1:0] i_sense_gain_select,
    input wire logic [1:0] i_sense_channel_select,
    input wire logic i_sense_output_enable,
    input wire logic i_temp_enable,
    input wire logic i_vdd_fail_enable,
    // Frame completion and what it reported
    input wire logic i_frame_done,
    input wire logic i_read_diag,
    input wire logic i_read_status,
    // Output commands
    input wire logic [NCH-1:0] i_out_cmd,
    input wire logic [NCH*`LDS_DUTY_W-1:0] i_duty,
    input wire logic [NCH-1:0] i_direct_in,
    input wire logic [NCH-1:0] i_prot_fault,
    // Analog comparators
    input wire logic [NCH-1:0] i_below_bulb,
    input wire logic [NCH-1:0] i_below_led,
    input wire logic i_overtemp_warn,
    // Supply and pin monitors
    input wire logic i_vdd_ok,
    input wire logic i_vdd_below_fail,
    input wire logic i_vdd_por,
    input wire logic i_pwr_ok,
    input wire logic i_pwr_por,
    input wire logic i_clamp,
    input wire logic i_gnd_lost,
    input wire logic i_logic_reset_low_n,
    // Outputs to the power stage
    output logic [NCH-1:0] o_switch_outputs,
    output logic o_fault_status_out_n,
    // Diagnostic flags
    output logic [NCH-1:0] o_lit_openload_flag,
    output logic o_overheat_warning_bit,
    output logic o_undervoltage_flag,
    // Sense pin routing
    output logic o_sense_current_on,
    output logic o_sense_temp_on,
    output logic [1:0] o_sense_channel,
    output logic o_sense_gain,
    // Supply state towards other blocks
    output logic o_failsafe,
    output logic o_prot_defaults,
    output logic o_fault_clear,
    output logic o_retry_clear
);

    lds_mode_type mode_q;
    lds_mode_type mode_d;

    logic [NCH-1:0] cfg_led_sel_q;
    logic [NCH-1:0] cfg_ol_dis_q;
    logic [NCH-1:0] cfg_gain_q;
    logic [1:0] cfg_sel_q;
    logic cfg_sense_en_q;
    logic cfg_temp_en_q;
    logic cfg_vdd_fail_en_q;

    logic [NCH-1:0] sw_q;
    logic [NCH-1:0] sw_d;
    logic fsb_q;
    logic warn_q;
    logic uv_q;
    logic cur_on_q;
    logic temp_on_q;
    logic [1:0] chan_q;
    logic gain_q;
    logic fclr_q;
    logic rclr_q;
    logic [NCH-1:0] ol_flag;
    logic [NCH-1:0] full_on;
    logic [NCH-1:0] below;

    // Supply decode
    wire both_por = i_pwr_por && i_vdd_por;
    wire any_por = i_pwr_por || both_por;
    wire vdd_fail = i_vdd_below_fail && cfg_vdd_fail_en_q;
    // Battery loss alone leaves the configuration in place
    wire cfg_rst = both_por || !i_vdd_ok || vdd_fail || !i_logic_reset_low_n; // see [R12] see [R17] see [R19]
    wire read_diag = i_frame_done && i_read_diag; // see [R20]
    wire read_stat = i_frame_done && i_read_status; // see [R20]

    assign mode_d = any_por ? MODE_POR :
                    (!i_vdd_ok ? MODE_FAILSAFE : MODE_NORMAL);

    // Output drive: ground loss wins, then clamp, then power-on reset
    wire [NCH-1:0] fs_drive = i_pwr_ok ? (i_direct_in & ~i_prot_fault) : `LDS_ALL_OFF; // see [R13]
    wire [NCH-1:0] nm_drive = i_pwr_ok ? (i_out_cmd & ~i_prot_fault) : `LDS_ALL_OFF;

    always_comb begin
        sw_d = `LDS_ALL_OFF;
        unique case (mode_d)
            MODE_NORMAL: sw_d = nm_drive;
            MODE_FAILSAFE: sw_d = fs_drive;
            MODE_POR: sw_d = `LDS_ALL_OFF; // see [R15]
        endcase
        if (i_clamp) begin
            sw_d = `LDS_ALL_ON; // see [R10]
        end
        if (i_gnd_lost) begin
            sw_d = `LDS_ALL_OFF; // see [R11]
        end
    end

    // Sense routing follows the next output state so it never leads the switch
    wire cur_sel = cfg_sense_en_q && !cfg_temp_en_q; // see [R6]
    wire cur_on_d = cur_sel && (mode_d == MODE_NORMAL) && sw_d[cfg_sel_q]; // see [R7] see [R8]
    wire temp_on_d = cfg_temp_en_q && (mode_d == MODE_NORMAL); // see [R6]

    // Open-load only upsets the flags; the fault pin ignores it
    wire fsb_d = !(|i_prot_fault || !i_pwr_ok); // see [R1]
    wire warn_d = !cfg_rst && (((mode_d == MODE_NORMAL) && i_overtemp_warn) ||
                  (warn_q && !read_diag)); // see [R9] see [R21]
    wire uv_d = !i_pwr_ok || (uv_q && !read_stat && !cfg_rst); // see [R18]
    wire rclr_d = (mode_d != mode_q) || any_por; // see [R15]

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cfg_led_sel_q <= '0;
            cfg_ol_dis_q <= '0;
            cfg_gain_q <= '0;
            cfg_sel_q <= 2'h0;
            cfg_sense_en_q <= 1'b0;
            cfg_temp_en_q <= 1'b0;
            cfg_vdd_fail_en_q <= 1'b0;
        end else if (cfg_rst) begin
            // Zeroed bits are also the fail-safe protection defaults
            cfg_led_sel_q <= '0; // see [R12] see [R14] see [R19]
            cfg_ol_dis_q <= '0;
            cfg_gain_q <= '0;
            cfg_sel_q <= 2'h0;
            cfg_sense_en_q <= 1'b0;
            cfg_temp_en_q <= 1'b0;
            cfg_vdd_fail_en_q <= 1'b0;
        end else if (i_cfg_wr) begin
            cfg_led_sel_q <= i_led_openload_select; // see [R2]
            cfg_ol_dis_q <= i_lit_openload_disable; // see [R5]
            cfg_gain_q <= i_sense_gain_select;
            cfg_sel_q <= i_sense_channel_select;
            cfg_sense_en_q <= i_sense_output_enable;
            cfg_temp_en_q <= i_temp_enable;
            cfg_vdd_fail_en_q <= i_vdd_fail_enable;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            mode_q <= MODE_POR;
            sw_q <= `LDS_ALL_OFF;
            fsb_q <= 1'b1;
            warn_q <= 1'b0;
            uv_q <= 1'b0;
            fclr_q <= 1'b1;
            rclr_q <= 1'b1;
        end else begin
            mode_q <= mode_d;
            sw_q <= sw_d;
            fsb_q <= fsb_d;
            warn_q <= warn_d;
            uv_q <= uv_d;
            fclr_q <= cfg_rst;
            rclr_q <= rclr_d;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cur_on_q <= 1'b0;
            temp_on_q <= 1'b0;
            chan_q <= 2'h0;
            gain_q <= 1'b0;
        end else begin
            cur_on_q <= cur_on_d;
            temp_on_q <= temp_on_d;
            chan_q <= cfg_sel_q;
            gain_q <= cfg_gain_q[cfg_sel_q];
        end
    end

    // One detector per output
    for (genvar k = 0; k < NCH; k++) begin : g_ch
        assign full_on[k] = (i_duty[k*`LDS_DUTY_W +: `LDS_DUTY_W] == `LDS_DUTY_FULL); // see [R3]
        assign below[k] = cfg_led_sel_q[k] ? i_below_led[k] : i_below_bulb[k]; // see [R2]

        lds_openload_chan #(
            .PERIOD_CYC(LED_OPENLOAD_SELECT_CYC)
        ) u_ol (
            .i_clk(i_clk),
            .i_rst_n(i_rst_n),
            .i_clr(cfg_rst),
            .i_on(sw_q[k]),
            .i_full_on(full_on[k]),
            .i_led_sel(cfg_led_sel_q[k]),
            .i_disable(cfg_ol_dis_q[k] || mode_q != MODE_NORMAL),
            .i_below(below[k]),
            .i_read_done(read_diag),
            .o_flag(ol_flag[k])
        );
    end

    assign o_switch_outputs = sw_q;
    assign o_fault_status_out_n = fsb_q;
    assign o_lit_openload_flag = ol_flag;
    assign o_overheat_warning_bit = warn_q;
    assign o_undervoltage_flag = uv_q;
    assign o_sense_current_on = cur_on_q;
    assign o_sense_temp_on = temp_on_q;
    assign o_sense_channel = chan_q;
    assign o_sense_gain = gain_q;
    assign o_failsafe = (mode_q == MODE_FAILSAFE);
    assign o_prot_defaults = (mode_q == MODE_FAILSAFE); // see [R14]
    assign o_fault_clear = fclr_q;
    assign o_retry_clear = rclr_q;

    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    a_ol_keeps_on: assert property ( // see [R1]
        (mode_d == MODE_NORMAL && i_pwr_ok && i_prot_fault == '0 && !i_clamp && !i_gnd_lost)
        |=> (o_switch_outputs == $past(i_out_cmd)) && o_fault_status_out_n)
        else $error("Output or fault pin disturbed in normal operation");

    a_ol_disabled: assert property ( // see [R5]
        ##1 ((ol_flag & $past(cfg_ol_dis_q) & ~$past(ol_flag)) == '0))
        else $error("Disabled channel raised open-load flag");

    a_ol_clear_read: assert property ( // see [R4]
        (|($past(ol_flag) & ~ol_flag)) |-> $past(read_diag) || $past(cfg_rst))
        else $error("Open-load flag cleared without a read");

    a_sense_gated: assert property ( // see [R7]
        o_sense_current_on |-> o_switch_outputs[o_sense_channel])
        else $error("Current copy active while selected output off");

    a_sense_failsafe: assert property ( // see [R8]
        (mode_d == MODE_FAILSAFE) |=> !o_sense_current_on ##1 !o_failsafe || !o_sense_current_on)
        else $error("Current copy active in fail-safe mode");

    a_warn_latch: assert property ( // see [R9]
        (mode_d == MODE_NORMAL && i_overtemp_warn && !cfg_rst) |=> o_overheat_warning_bit)
        else $error("Overheat warning not latched");

    a_clamp_all_on: assert property ( // see [R10]
        (i_clamp && !i_gnd_lost) |=> o_switch_outputs == `LDS_ALL_ON)
        else $error("Clamp did not switch all outputs on");

    a_gnd_off: assert property ( // see [R11]
        i_gnd_lost |=> o_switch_outputs == `LDS_ALL_OFF)
        else $error("Ground loss left an output on");

    a_vdd_cfg_reset: assert property ( // see [R12]
        !i_vdd_ok |=> cfg_led_sel_q == '0 && !cfg_sense_en_q && o_fault_clear)
        else $error("Configuration survived logic supply loss");

    a_failsafe_direct: assert property ( // see [R13]
        (mode_d == MODE_FAILSAFE && i_pwr_ok && !i_clamp && !i_gnd_lost)
        |=> o_switch_outputs == ($past(i_direct_in) & ~$past(i_prot_fault)))
        else $error("Direct inputs not driving outputs in fail-safe");

    a_por_off: assert property ( // see [R15]
        (i_pwr_por && !i_clamp && !i_gnd_lost) |=> o_switch_outputs == '0 && o_retry_clear)
        else $error("Power-on reset did not turn outputs off");

    a_cfg_kept: assert property ( // see [R17]
        (!i_pwr_ok && !i_pwr_por && !cfg_rst && !i_cfg_wr) |=> $stable(cfg_led_sel_q))
        else $error("Configuration lost on battery loss");

    a_uv_flag: assert property ( // see [R18]
        !i_pwr_ok |=> o_undervoltage_flag)
        else $error("Battery loss not flagged");

    a_both_por: assert property ( // see [R19]
        both_por |=> ol_flag == '0 && !o_overheat_warning_bit && cfg_ol_dis_q == '0)
        else $error("Latched state survived full power-on reset");

    c_failsafe: cover property (mode_q == MODE_NORMAL ##1 mode_q == MODE_FAILSAFE);
    c_clamp: cover property (i_clamp && |i_prot_fault);
    c_ol_cycle: cover property ($rose(ol_flag[0]) ##[1:200] $fell(ol_flag[0]));
    c_sense_on: cover property (o_sense_current_on && o_sense_gain);

endmodule : lds_load_diag

// File: lds_load_diag_tb.sv
// Self-checking bench for the load diagnostic and supply-loss logic
`timescale 1ns/1ps
module lds_load_diag_tb;
    import lds_pkg::*;
    localparam int LED_OPENLOAD_SELECT = 8;
    logic i_clk = 1'h0;
    logic i_rst_n = 1'h0;
    logic start = 1'h0;
    logic busy, cfg_wr, frame_done, read_diag, read_status;
    logic [1:0] hkind = 2'h0;
    logic [1:0] ch_sel = 2'h0;
    logic [3:0] led_sel = 4'h0, ol_dis = 4'h0, gain_sel = 4'h0, out_cmd = 4'h0;
    logic [3:0] direct_in = 4'h0, prot = 4'h0, below_b = 4'h0, below_l = 4'h0;
    logic sense_en = 1'h0, temp_en = 1'h0, vfail_en = 1'h0, ot_warn = 1'h0;
    logic vdd_ok = 1'h1, below_fail = 1'h0, vdd_por = 1'h0, pwr_ok = 1'h1;
    logic pwr_por = 1'h0, clamp = 1'h0, gnd_lost = 1'h0, rst_pin_n = 1'h1;
    logic [27:0] duty = {4{7'h7F}};
    logic [3:0] sw, flag;
    logic fault_n, ot_bit, uv, cur_on, temp_on, gain, fs, defs, fclr, rclr;
    logic [1:0] sense_ch;
    logic [31:0] rnd = 32'hC03736AD;
    int miscompares = 0;
    int check_count = 0;
    int k, n;

    always #5 i_clk = ~i_clk;

    lds_host_model lds_host_model_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_start(start),
        .i_kind(hkind), .o_busy(busy), .o_cfg_wr(cfg_wr), .o_frame_done(frame_done),
        .o_read_diag(read_diag), .o_read_status(read_status));

    lds_load_diag #(.NCH(4), .LED_OPENLOAD_SELECT_CYC(LED_OPENLOAD_SELECT)) lds_load_diag_i (.i_clk(i_clk),
        .i_rst_n(i_rst_n), .i_cfg_wr(cfg_wr), .i_led_openload_select(led_sel),
        .i_lit_openload_disable(ol_dis), .i_sense_gain_select(gain_sel),
        .i_sense_channel_select(ch_sel), .i_sense_output_enable(sense_en),
        .i_temp_enable(temp_en), .i_vdd_fail_enable(vfail_en), .i_frame_done(frame_done),
        .i_read_diag(read_diag), .i_read_status(read_status), .i_out_cmd(out_cmd),
        .i_duty(duty), .i_direct_in(direct_in), .i_prot_fault(prot), .i_below_bulb(below_b),
        .i_below_led(below_l), .i_overtemp_warn(ot_warn), .i_vdd_ok(vdd_ok),
        .i_vdd_below_fail(below_fail), .i_vdd_por(vdd_por), .i_pwr_ok(pwr_ok),
        .i_pwr_por(pwr_por), .i_clamp(clamp), .i_gnd_lost(gnd_lost),
        .i_logic_reset_low_n(rst_pin_n), .o_switch_outputs(sw), .o_fault_status_out_n(fault_n),
        .o_lit_openload_flag(flag), .o_overheat_warning_bit(ot_bit), .o_undervoltage_flag(uv),
        .o_sense_current_on(cur_on), .o_sense_temp_on(temp_on), .o_sense_channel(sense_ch),
        .o_sense_gain(gain), .o_failsafe(fs), .o_prot_defaults(defs), .o_fault_clear(fclr),
        .o_retry_clear(rclr));

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] v;
        v = s ^ (s << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction : xs

    function automatic logic [3:0] ol_exp(input logic [3:0] below, input logic [3:0] dis);
        return below & ~dis;
    endfunction : ol_exp

    task automatic end_of_test;
        if (miscompares == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : end_of_test

    task automatic chk_bit(input string nm, input logic e, input logic g);
        check_count++;
        if (g !== e) begin
            miscompares++;
            $display("mismatch %s expected %b seen %b", nm, e, g);
        end
    endtask : chk_bit

    task automatic chk_vec(input string nm, input logic [3:0] e, input logic [3:0] g);
        check_count++;
        if (g !== e) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_vec

    task automatic adv(input int c);
        repeat (c) @(posedge i_clk);
    endtask : adv

    task automatic settle(input int c);
        repeat (c) @(posedge i_clk);
        #1;
    endtask : settle

    // One whole frame; returns just after the edge on which the block takes its done strobe
    task automatic host(input logic [1:0] kind);
        int w;
        w = 0;
        @(posedge i_clk);
        start <= 1'h1;
        hkind <= kind;
        @(posedge i_clk);
        start <= 1'h0;
        do begin
            settle(1);
            w++;
        end while (busy === 1'h1 && w < 40);
        if (w >= 40) begin
            miscompares++;
            end_of_test();
        end
        settle(1);
    endtask : host

    initial begin
        repeat (20000) @(posedge i_clk);
        miscompares++;
        end_of_test();
    end

    initial begin
        adv(2);
        i_rst_n <= 1'h1;
        settle(1);
        chk_vec("openload_flag", 4'h0, flag);
        adv(1);
        out_cmd <= 4'hF;
        host(2'h0);
        for (k = 0; k < 4; k++) begin
            rnd = xs(rnd);
            adv(1);
            below_b <= 4'h1 << k;
            below_l <= rnd[3:0];
            settle(1);
            chk_vec("openload_flag", 4'h1 << k, flag);
            chk_vec("switch_outputs", 4'hF, sw);
            chk_bit("fault_pin", 1'h1, fault_n);
            host(2'h1);
            chk_vec("openload_flag", 4'h1 << k, flag);
            adv(1);
            below_b <= 4'h0;
            host(2'h2);
            chk_vec("openload_flag", 4'h1 << k, flag);
            host(2'h1);
            chk_vec("openload_flag", 4'h0, flag);
        end
        rnd = xs(rnd);
        adv(1);
        below_l <= 4'h0;
        ol_dis <= rnd[7:4];
        host(2'h0);
        adv(1);
        below_b <= 4'hF;
        settle(2);
        chk_vec("openload_flag", ol_exp(4'hF, rnd[7:4]), flag);
        adv(1);
        below_b <= 4'h0;
        ol_dis <= 4'h0;
        led_sel <= 4'hF;
        host(2'h0);
        host(2'h1);
        k = int'(rnd[9:8]);
        adv(1);
        out_cmd <= 4'h0;
        settle(2);
        adv(1);
        out_cmd <= 4'hF;
        below_l <= 4'h1 << k;
        n = 0;
        do begin
            settle(1);
            n++;
        end while (flag === 4'h0 && n < 4 * LED_OPENLOAD_SELECT);
        chk_vec("openload_flag", 4'h1 << k, flag);
        chk_bit("led_period", 1'h1, n >= LED_OPENLOAD_SELECT - 1 && n <= LED_OPENLOAD_SELECT + 3);
        adv(1);
        below_l <= 4'h0;
        host(2'h1);
        adv(1);
        duty[7*k +: 7] <= 7'h7E;
        below_l <= 4'h1 << k;
        settle(3 * LED_OPENLOAD_SELECT);
        chk_vec("openload_flag", 4'h0, flag);
        adv(1);
        below_l <= 4'h0;
        duty <= {4{7'h7F}};
        ot_warn <= 1'h1;
        settle(1);
        chk_bit("overheat", 1'h1, ot_bit);
        host(2'h1);
        chk_bit("overheat", 1'h1, ot_bit);
        adv(1);
        ot_warn <= 1'h0;
        host(2'h2);
        chk_bit("overheat", 1'h1, ot_bit);
        host(2'h1);
        chk_bit("overheat", 1'h0, ot_bit);
        for (k = 0; k < 4; k++) begin
            rnd = xs(rnd);
            adv(1);
            sense_en <= 1'h1;
            ch_sel <= k[1:0];
            gain_sel <= rnd[3:0];
            host(2'h0);
            settle(1);
            chk_bit("sense_current", 1'h1, cur_on);
            chk_vec("sense_channel", 4'(k), {2'h0, sense_ch});
            chk_bit("sense_gain", rnd[k], gain);
            adv(1);
            out_cmd <= 4'hF ^ (4'h1 << k);
            settle(2);
            chk_bit("sense_current", 1'h0, cur_on);
            adv(1);
            out_cmd <= 4'hF;
        end
        adv(1);
        temp_en <= 1'h1;
        host(2'h0);
        settle(1);
        chk_bit("sense_temp", 1'h1, temp_on);
        chk_bit("sense_current", 1'h0, cur_on);
        adv(1);
        temp_en <= 1'h0;
        ch_sel <= 2'h2;
        out_cmd <= 4'h0;
        host(2'h0);
        adv(1);
        pwr_ok <= 1'h0;
        settle(2);
        chk_bit("undervoltage", 1'h1, uv);
        chk_vec("sense_channel", 4'h2, {2'h0, sense_ch});
        adv(1);
        pwr_ok <= 1'h1;
        host(2'h2);
        chk_bit("undervoltage", 1'h0, uv);
        rnd = xs(rnd);
        adv(1);
        vdd_ok <= 1'h0;
        direct_in <= rnd[3:0];
        settle(3);
        chk_bit("failsafe", 1'h1, fs);
        chk_bit("prot_defaults", 1'h1, defs);
        chk_bit("sense_current", 1'h0, cur_on);
        chk_bit("fault_clear", 1'h1, fclr);
        chk_vec("switch_outputs", rnd[3:0], sw);
        adv(1);
        direct_in <= rnd[7:4];
        settle(1);
        chk_vec("switch_outputs", rnd[7:4], sw);
        adv(1);
        vdd_ok <= 1'h1;
        settle(3);
        chk_vec("sense_channel", 4'h0, {2'h0, sense_ch});
        adv(1);
        ch_sel <= 2'h3;
        vfail_en <= 1'h1;
        host(2'h0);
        adv(1);
        below_fail <= 1'h1;
        // The reset also clears the fail enable, so the clear lasts one cycle
        settle(1);
        chk_bit("fault_clear", 1'h1, fclr);
        adv(1);
        below_fail <= 1'h0;
        out_cmd <= 4'hF;
        settle(3);
        chk_vec("sense_channel", 4'h0, {2'h0, sense_ch});
        adv(1);
        pwr_por <= 1'h1;
        settle(2);
        chk_vec("switch_outputs", 4'h0, sw);
        chk_bit("retry_clear", 1'h1, rclr);
        adv(1);
        pwr_por <= 1'h0;
        settle(3);
        chk_vec("switch_outputs", 4'hF, sw);
        adv(1);
        prot <= 4'hF;
        clamp <= 1'h1;
        settle(2);
        chk_vec("switch_outputs", 4'hF, sw);
        adv(1);
        gnd_lost <= 1'h1;
        settle(2);
        chk_vec("switch_outputs", 4'h0, sw);
        adv(1);
        clamp <= 1'h0;
        gnd_lost <= 1'h0;
        prot <= 4'h0;
        ot_warn <= 1'h1;
        settle(2);
        chk_bit("overheat", 1'h1, ot_bit);
        adv(1);
        ot_warn <= 1'h0;
        vdd_por <= 1'h1;
        pwr_por <= 1'h1;
        settle(2);
        chk_bit("overheat", 1'h0, ot_bit);
        chk_bit("fault_clear", 1'h1, fclr);
        end_of_test();
    end
endmodule : lds_load_diag_tb

// File: lds_openload_chan.sv
// Lit open-load detector and read-to-clear flag for one output
`timescale 1ns/1ps
`include "lds_cfg.svh"

module lds_openload_chan
    import lds_pkg::*;
#(
    parameter int PERIOD_CYC = `LDS_LED_OPENLOAD_SELECT_CYCLES
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Channel state
    input wire logic i_clr,
    input wire logic i_on,
    input wire logic i_full_on,
    input wire logic i_led_sel,
    input wire logic i_disable,
    input wire logic i_below,
    input wire logic i_read_done,
    // Flag
    output logic o_flag
);

    localparam int CW = $clog2(PERIOD_CYC + 1);
    localparam logic [CW-1:0] LAST = CW'(PERIOD_CYC - 1);

    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    logic flag_q;
    logic flag_d;

    // LED loads only count while continuously fully on
    wire led_run = i_on && i_full_on && i_led_sel;
    wire led_tick = led_run && (cnt_q == LAST);
    wire eval = i_led_sel ? led_tick : i_on;
    wire set = !i_disable && eval && i_below;
    wire cond_gone = !(i_on && i_below);
    wire clr = i_read_done && cond_gone;

    assign cnt_d = (!led_run || led_tick) ? '0 : cnt_q + CW'(1); // see [R3]
    // Set beats the read clear, so a persisting fault shows again
    assign flag_d = !i_clr && (set || (flag_q && !clr)); // see [R1] see [R4] see [R5] see [R21]

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_q <= '0;
            flag_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            flag_q <= flag_d;
        end
    end

    assign o_flag = flag_q;

    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    a_led_only_period: assert property ( // see [R3]
        (i_led_sel && !flag_q && !i_clr) ##1 flag_q |-> $past(led_tick))
        else $error("LED open-load flag set outside a detection period end");

    c_led_detect: cover property (led_tick && i_below && !i_disable);

endmodule : lds_openload_chan

// File: lds_pkg.sv
// Types shared by the load diagnostic and supply-loss logic
package lds_pkg;

    typedef enum logic [2:0] {
        MODE_NORMAL = 3'h1,
        MODE_FAILSAFE = 3'h2,
        MODE_POR = 3'h4
    } lds_mode_type;

endpackage : lds_pkg
